/* File: src/drp_defines.vh */
`ifndef DRP_DEFINES_VH
`define DRP_DEFINES_VH

// ==========================================
// register offsets
`define DRP_OFF_READY   8'h00
`define DRP_OFF_UVT     8'h04
`define DRP_OFF_RATED   8'h08
`define DRP_OFF_POL     8'h0c
`define DRP_OFF_STYPE   8'h10
`define DRP_OFF_VSF     8'h14
`define DRP_OFF_VSE     8'h18
`define DRP_OFF_STATE   8'h1c
`define DRP_OFF_IRQST   8'h20
`define DRP_OFF_IRQMSK  8'h24
`define DRP_IDX_READY   4'h0
`define DRP_IDX_UVT     4'h1
`define DRP_IDX_RATED   4'h2
`define DRP_IDX_POL     4'h3
`define DRP_IDX_STYPE   4'h4
`define DRP_IDX_VSF     4'h5
`define DRP_IDX_VSE     4'h6
`define DRP_IDX_STATE   4'h7
`define DRP_IDX_IRQST   4'h8
`define DRP_IDX_IRQMSK  4'h9
`define DRP_IDX_NONE    4'hf

// ==========================================
// field layouts and masks
`define DRP_READY_MASK  16'h0017
`define DRP_POL_MASK    16'h000f
`define DRP_STYPE_MASK  16'h007f
`define DRP_RDY_UV      0
`define DRP_RDY_EN      1
`define DRP_RDY_EXT     2
`define DRP_RLY_BIT     4
`define DRP_ST_READY    0
`define DRP_ST_UVLOW    1
`define DRP_ST_UVFLT    2
`define DRP_ST_PREOP    3
`define DRP_ST_RELAY    4

// ==========================================
// reset values and ranges, 0.1 V units
`define DRP_UVT_RESET   16'h01a4
`define DRP_UVT_MAX     16'h1d4c
`define DRP_RATED_RESET 16'h021c
`define DRP_RATED_MIN   16'h01e0
`define DRP_RATED_MAX   16'h1d4c
`define DRP_UV_PCT      8'h41
`define DRP_PCT_DEN     8'h64

// ==========================================
// scaling constants
`define DRP_VSF_NUM     32'h0020_0000
`define DRP_VSF_MAX     32'h0000_ffff
`define DRP_VSE_MAX     16'h0020
`define DRP_VSE_MIN     16'hffe0

// ==========================================
// interrupt status bits
`define DRP_IRQ_UV      0
`define DRP_IRQ_REFUSE  1
`define DRP_IRQ_RDYLOST 2
`define DRP_IRQ_N       3

`endif

/* File: src/drp_uv_monitor.v */
`timescale 1ns/10ps
`include "drp_defines.vh"
module drp_uv_monitor #(
  parameter W = 16
) (
  pclk,
  presetn,
  ce,
  uv_select,
  controlled_mode,
  min_voltage,
  rated_voltage,
  bus_voltage,
  uv_low,
  uv_fault
);
  input  wire         pclk;
  input  wire         presetn;
  input  wire         ce;
  input  wire         uv_select;
  input  wire         controlled_mode;
  input  wire [W-1:0] min_voltage;
  input  wire [W-1:0] rated_voltage;
  input  wire [W-1:0] bus_voltage;
  output reg          uv_low;
  output reg          uv_fault;

  reg  [W-1:0]   thresh_reg;
  wire [W+7:0]   pct_prod;
  wire [W+7:0]   pct_quot;
  wire [W-1:0]   thresh_next;
  wire           below;

  // ==========================================
  // threshold choice
  assign pct_prod = rated_voltage * `DRP_UV_PCT;
  assign pct_quot = pct_prod / `DRP_PCT_DEN;
  assign thresh_next = (min_voltage == {W{1'b0}}) ? pct_quot[W-1:0] : min_voltage;
  assign below = bus_voltage < thresh_reg;

  // ==========================================
  // supervision
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_reg <= `DRP_UVT_RESET;
      uv_low     <= 1'b0;
      uv_fault   <= 1'b0;
    end else if (ce) begin
      thresh_reg <= thresh_next;
      uv_low     <= uv_select & below;
      uv_fault   <= uv_select & controlled_mode & below;
    end
  end
endmodule // drp_uv_monitor

/* File: src/drp_params.v */
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "drp_defines.vh"
module drp_params #(
  parameter        ADDR_W       = 8,
  parameter [31:0] MAX_VELOCITY = 32'h0000_0040,
  // exponent default is arbitrary
  parameter [15:0] VEL_EXP      = 16'h0000
) (
  pclk,
  presetn,
  ce,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  preop_state,
  controlled_mode,
  drive_ok,
  enable_in,
  ext_ok,
  bus_voltage,
  vel_cmd_in,
  vel_add_in,
  vel_fb1_in,
  vel_fb2_in,
  vel_cmd_out,
  vel_add_out,
  vel_fb1_out,
  vel_fb2_out,
  ready_to_operate,
  emergency_relay,
  undervoltage_fault,
  irq
);
  input  wire              pclk;
  input  wire              presetn;
  input  wire              ce;
  input  wire              psel;
  input  wire              penable;
  input  wire              pwrite;
  input  wire [ADDR_W-1:0] paddr;
  input  wire [31:0]       pwdata;
  output reg  [31:0]       prdata;
  output reg               pready;
  output reg               pslverr;
  input  wire              preop_state;
  input  wire              controlled_mode;
  input  wire              drive_ok;
  input  wire              enable_in;
  input  wire              ext_ok;
  input  wire [15:0]       bus_voltage;
  input  wire [15:0]       vel_cmd_in;
  input  wire [15:0]       vel_add_in;
  input  wire [15:0]       vel_fb1_in;
  input  wire [15:0]       vel_fb2_in;
  output wire [15:0]       vel_cmd_out;
  output wire [15:0]       vel_add_out;
  output wire [15:0]       vel_fb1_out;
  output wire [15:0]       vel_fb2_out;
  output reg               ready_to_operate;
  output reg               emergency_relay;
  output reg               undervoltage_fault;
  output reg               irq;

  // ==========================================
  // fixed scaling values
  localparam [31:0] VSF_RAW = `DRP_VSF_NUM / MAX_VELOCITY;
  localparam [31:0] VSF_SAT = (VSF_RAW > `DRP_VSF_MAX) ? `DRP_VSF_MAX : VSF_RAW;
  localparam [15:0] VSF     = VSF_SAT[15:0];
  localparam [15:0] VSE     =
    ($signed(VEL_EXP) > $signed(`DRP_VSE_MAX)) ? `DRP_VSE_MAX :
    ($signed(VEL_EXP) < $signed(`DRP_VSE_MIN)) ? `DRP_VSE_MIN : VEL_EXP;

  // ==========================================
  // address decode
  function [3:0] reg_index;
    input [ADDR_W-1:0] a;
    begin
      case (a[7:0])
        `DRP_OFF_READY:  reg_index = `DRP_IDX_READY;
        `DRP_OFF_UVT:    reg_index = `DRP_IDX_UVT;
        `DRP_OFF_RATED:  reg_index = `DRP_IDX_RATED;
        `DRP_OFF_POL:    reg_index = `DRP_IDX_POL;
        `DRP_OFF_STYPE:  reg_index = `DRP_IDX_STYPE;
        `DRP_OFF_VSF:    reg_index = `DRP_IDX_VSF;
        `DRP_OFF_VSE:    reg_index = `DRP_IDX_VSE;
        `DRP_OFF_STATE:  reg_index = `DRP_IDX_STATE;
        `DRP_OFF_IRQST:  reg_index = `DRP_IDX_IRQST;
        `DRP_OFF_IRQMSK: reg_index = `DRP_IDX_IRQMSK;
        default:         reg_index = `DRP_IDX_NONE;
      endcase
      // upper address bits must be clear; a shift stays legal at 8 bits
      if ((a >> 8) != {ADDR_W{1'b0}}) begin
        reg_index = `DRP_IDX_NONE;
      end
    end
  endfunction

  // ==========================================
  // parameter registers
  reg  [15:0] ready_condition_config_reg;
  reg  [15:0] undervoltage_threshold_reg;
  reg  [15:0] rated_bus_voltage_reg;
  reg  [15:0] velocity_polarity_reg;
  reg  [15:0] velocity_scaling_type_reg;
  reg  [`DRP_IRQ_N-1:0] irq_status_reg;
  reg  [`DRP_IRQ_N-1:0] irq_mask_reg;
  reg                   ready_prev_reg;
  reg                   fault_prev_reg;

  wire [3:0]  idx;
  wire        access;
  wire        setup_done;
  wire        complete;
  wire        wr_done;
  wire        rd_status;
  wire        uv_low;
  wire        uv_fault;
  wire [2:0]  ready_sel;
  reg         wr_ok;
  reg         idx_ok;
  reg  [31:0] rd_next;
  reg         ready_next;
  reg         relay_next;
  reg  [`DRP_IRQ_N-1:0] ev;
  reg  [`DRP_IRQ_N-1:0] clr;

  assign idx        = reg_index(paddr);
  assign access     = psel & penable;
  // first access cycle loads the answer, second one completes
  assign setup_done = access & ~pready;
  assign complete   = access & pready;
  assign wr_done    = complete & pwrite & ~pslverr;
  assign rd_status  = complete & ~pwrite & (reg_index(paddr) == `DRP_IDX_IRQST);
  assign ready_sel  = ready_condition_config_reg[2:0];

  // ==========================================
  // write check
  always @* begin
    wr_ok  = 1'b0;
    idx_ok = 1'b1;
    case (idx)
      `DRP_IDX_READY:  wr_ok = 1'b1;
      `DRP_IDX_UVT:    wr_ok = pwdata[15:0] <= `DRP_UVT_MAX;
      `DRP_IDX_RATED:  wr_ok = (pwdata[15:0] >= `DRP_RATED_MIN) &&
                               (pwdata[15:0] <= `DRP_RATED_MAX);
      `DRP_IDX_POL:    wr_ok = 1'b1;
      `DRP_IDX_STYPE:  wr_ok = 1'b1;
      `DRP_IDX_IRQMSK: wr_ok = 1'b1;
      `DRP_IDX_NONE:   idx_ok = 1'b0;
      default:         wr_ok = 1'b0;
    endcase
  end

  // ==========================================
  // read mux
  always @* begin
    rd_next = 32'h0000_0000;
    case (idx)
      `DRP_IDX_READY:  rd_next[15:0] = ready_condition_config_reg;
      `DRP_IDX_UVT:    rd_next[15:0] = undervoltage_threshold_reg;
      `DRP_IDX_RATED:  rd_next[15:0] = rated_bus_voltage_reg;
      `DRP_IDX_POL:    rd_next[15:0] = velocity_polarity_reg;
      `DRP_IDX_STYPE:  rd_next[15:0] = velocity_scaling_type_reg;
      `DRP_IDX_VSF:    rd_next[15:0] = VSF;
      `DRP_IDX_VSE:    rd_next[15:0] = VSE;
      `DRP_IDX_STATE: begin
        rd_next[`DRP_ST_READY] = ready_to_operate;
        rd_next[`DRP_ST_UVLOW] = uv_low;
        rd_next[`DRP_ST_UVFLT] = undervoltage_fault;
        rd_next[`DRP_ST_PREOP] = preop_state;
        rd_next[`DRP_ST_RELAY] = emergency_relay;
      end
      `DRP_IDX_IRQST:  rd_next[`DRP_IRQ_N-1:0] = irq_status_reg;
      `DRP_IDX_IRQMSK: rd_next[`DRP_IRQ_N-1:0] = irq_mask_reg;
      default:         rd_next = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // bus handshake
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup_done;
      if (setup_done) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_next;
        pslverr <= ~idx_ok | (pwrite & ~(wr_ok & preop_state));
      end else if (complete) begin
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================
  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_condition_config_reg <= 16'h0000;
      undervoltage_threshold_reg <= `DRP_UVT_RESET;
      rated_bus_voltage_reg      <= `DRP_RATED_RESET;
      velocity_polarity_reg      <= 16'h0000;
      velocity_scaling_type_reg  <= 16'h0000;
      irq_mask_reg               <= {`DRP_IRQ_N{1'b0}};
    end else if (ce && wr_done) begin
      case (idx)
        `DRP_IDX_READY:
          ready_condition_config_reg <= pwdata[15:0] & `DRP_READY_MASK;
        `DRP_IDX_UVT:
          undervoltage_threshold_reg <= pwdata[15:0];
        `DRP_IDX_RATED:
          rated_bus_voltage_reg <= pwdata[15:0];
        `DRP_IDX_POL:
          velocity_polarity_reg <= pwdata[15:0] & `DRP_POL_MASK;
        `DRP_IDX_STYPE:
          velocity_scaling_type_reg <= pwdata[15:0] & `DRP_STYPE_MASK;
        `DRP_IDX_IRQMSK:
          irq_mask_reg <= pwdata[`DRP_IRQ_N-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // undervoltage supervision
  drp_uv_monitor #(
    .W (16)
  ) u_uv (
    .pclk            (pclk),
    .presetn         (presetn),
    .ce              (ce),
    .uv_select       (ready_sel[`DRP_RDY_UV]),
    .controlled_mode (controlled_mode),
    .min_voltage     (undervoltage_threshold_reg),
    .rated_voltage   (rated_bus_voltage_reg),
    .bus_voltage     (bus_voltage),
    .uv_low          (uv_low),
    .uv_fault        (uv_fault)
  );

  // ==========================================
  // readiness and relay
  always @* begin
    ready_next = drive_ok &
                 (~ready_sel[`DRP_RDY_UV]  | ~uv_low) &
                 (~ready_sel[`DRP_RDY_EN]  | enable_in) &
                 (~ready_sel[`DRP_RDY_EXT] | ext_ok);
    if (ready_condition_config_reg[`DRP_RLY_BIT]) begin
      relay_next = drive_ok & ~uv_fault;
    end else begin
      relay_next = ready_next;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_to_operate   <= 1'b0;
      emergency_relay    <= 1'b0;
      undervoltage_fault <= 1'b0;
      ready_prev_reg     <= 1'b0;
      fault_prev_reg     <= 1'b0;
    end else if (ce) begin
      ready_to_operate   <= ready_next;
      emergency_relay    <= relay_next;
      undervoltage_fault <= uv_fault;
      ready_prev_reg     <= ready_to_operate;
      fault_prev_reg     <= undervoltage_fault;
    end
  end

  // ==========================================
  // interrupt status
  always @* begin
    ev                  = {`DRP_IRQ_N{1'b0}};
    ev[`DRP_IRQ_UV]     = undervoltage_fault & ~fault_prev_reg;
    ev[`DRP_IRQ_REFUSE] = complete & pwrite & pslverr;
    ev[`DRP_IRQ_RDYLOST] = ready_prev_reg & ~ready_to_operate;
    // only bits shown to software are cleared, so later events survive
    clr = rd_status ? prdata[`DRP_IRQ_N-1:0] : {`DRP_IRQ_N{1'b0}};
  end

  genvar g;
  generate
    for (g = 0; g < `DRP_IRQ_N; g = g + 1) begin : g_irq
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_status_reg[g] <= 1'b0;
        end else if (ce) begin
          // set wins over read clear
          irq_status_reg[g] <= ev[g] | (irq_status_reg[g] & ~clr[g]);
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ==========================================
  // velocity polarity path
  wire [63:0] vel_in;
  wire [63:0] vel_out;

  assign vel_in      = {vel_fb2_in, vel_fb1_in, vel_add_in, vel_cmd_in};
  assign vel_cmd_out = vel_out[15:0];
  assign vel_add_out = vel_out[31:16];
  assign vel_fb1_out = vel_out[47:32];
  assign vel_fb2_out = vel_out[63:48];

  generate
    for (g = 0; g < 4; g = g + 1) begin : g_vel
      reg  [15:0] v_reg;
      wire [15:0] v_in;
      wire [15:0] v_neg;
      assign v_in  = vel_in[16*g +: 16];
      // most negative value saturates instead of wrapping
      assign v_neg = (v_in == 16'h8000) ? 16'h7fff : (~v_in + 16'h0001);
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          v_reg <= 16'h0000;
        end else if (ce) begin
          v_reg <= velocity_polarity_reg[g] ? v_neg : v_in;
        end
      end
      assign vel_out[16*g +: 16] = v_reg;
    end
  endgenerate

endmodule // drp_params

/* File: sim/drp_params_sva.sv */
`timescale 1ns/10ps
module drp_params_sva #(
  parameter ADDR_W = 8
) (
  input logic              pclk,
  input logic              presetn,
  input logic              ce,
  input logic              psel,
  input logic              penable,
  input logic              pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0]       pwdata,
  input logic [31:0]       prdata,
  input logic              pready,
  input logic              pslverr,
  input logic              preop_state,
  input logic              controlled_mode,
  input logic              drive_ok,
  input logic [15:0]       vel_cmd_in,
  input logic [15:0]       vel_fb1_in,
  input logic [15:0]       vel_cmd_out,
  input logic [15:0]       vel_fb1_out,
  input logic              ready_to_operate,
  input logic              undervoltage_fault
);
  logic [3:0] pol_q;

  // most negative value saturates, no wrap to itself
  function automatic logic [15:0] pol_fn(input logic inv, input logic [15:0] v);
    return !inv ? v : (v == 16'h8000) ? 16'h7fff : -v;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pol_q <= 4'h0;
    else if (pready && psel && pwrite && !pslverr && paddr == 8'h0c)
      pol_q <= pwdata[3:0];
  end

  // ==========================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_first_access;
    psel && penable;
  endsequence

  a_one_wait: assert property (s_setup ##1 s_first_access |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ro_refused: assert property (pready && pwrite &&
      paddr inside {8'h14, 8'h18, 8'h1c, 8'h20} |-> pslverr)
    else $error("write to read-only place accepted");
  a_preop_refused: assert property (pready && pwrite && !preop_state |-> pslverr)
    else $error("write outside pre-operational accepted");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_vel_cmd_pol: assert property ($past(ce) |->
      vel_cmd_out == pol_fn($past(pol_q[0]), $past(vel_cmd_in)))
    else $error("command velocity polarity wrong");
  a_vel_fb1_pol: assert property ($past(ce) |->
      vel_fb1_out == pol_fn($past(pol_q[2]), $past(vel_fb1_in)))
    else $error("feedback one polarity wrong");
  a_ce_freeze: assert property (!ce |=> $stable(vel_cmd_out) && $stable(vel_fb1_out))
    else $error("velocity output moved while clock enable low");
  a_ready_needs_ok: assert property (!$past(drive_ok) |-> !ready_to_operate)
    else $error("ready without base condition");
  a_uv_ctrl: assert property (!controlled_mode [*4] |-> !undervoltage_fault)
    else $error("undervoltage fault outside controlled mode");
endmodule // drp_params_sva

/* File: sim/drp_params_tb_top.sv */
`timescale 1ns/10ps
module drp_params_tb_top;
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, re;
  logic        preop_state = 1, controlled_mode = 0, drive_ok = 0, enable_in = 0, ext_ok = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rv;
  logic [15:0] bus_voltage = 16'h1000, vel_cmd_in = 16'h0000, vel_add_in = 16'h0000;
  logic [15:0] vel_fb1_in = 16'h0000, vel_fb2_in = 16'h0000;
  wire  [31:0] prdata;
  wire  [15:0] vel_cmd_out, vel_add_out, vel_fb1_out, vel_fb2_out;
  wire         pready, pslverr, ready_to_operate, emergency_relay, undervoltage_fault, irq;
  int          err_count = 0, cmp_count = 0;
  localparam logic [31:0] VSF_EXP = 32'h0020_0000 / 32'h0000_0040;
  logic [7:0]  ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24};
  logic [15:0] rx [9] = '{16'h0000, 16'h01a4, 16'h021c, 16'h0000, 16'h0000, VSF_EXP[15:0],
                          16'hfff0, 16'h0000, 16'h0000};
  logic [7:0]  ma [3] = '{8'h00, 8'h0c, 8'h10};
  logic [15:0] mx [3] = '{16'h0017, 16'h000f, 16'h007f};

  drp_params #(.ADDR_W(8), .MAX_VELOCITY(32'h0000_0040), .VEL_EXP(16'hfff0)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .preop_state(preop_state), .controlled_mode(controlled_mode),
    .drive_ok(drive_ok), .enable_in(enable_in), .ext_ok(ext_ok), .bus_voltage(bus_voltage),
    .vel_cmd_in(vel_cmd_in), .vel_add_in(vel_add_in), .vel_fb1_in(vel_fb1_in),
    .vel_fb2_in(vel_fb2_in), .vel_cmd_out(vel_cmd_out), .vel_add_out(vel_add_out),
    .vel_fb1_out(vel_fb1_out), .vel_fb2_out(vel_fb2_out),
    .ready_to_operate(ready_to_operate), .emergency_relay(emergency_relay),
    .undervoltage_fault(undervoltage_fault), .irq(irq)
  );

  initial forever #2 pclk = ~pclk;

  // ==========================================
  // compare and bus tasks
  task chk_word(string nm, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task chk_bit(string nm, logic exp, logic got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // no fixed latency assumed, only the watchdog ends a silent wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wr(logic [7:0] a, logic [15:0] d, logic xe);
    apb(1, a, {16'h0000, d});
    chk_bit("pslverr", xe, re);
  endtask
  task rd(string nm, logic [7:0] a, logic [15:0] xd, logic xe);
    apb(0, a, 32'h0000_0000);
    chk_bit("pslverr", xe, re);
    chk_word(nm, {16'h0000, xd}, rv);
  endtask
  task step(int n);
    repeat (n) @(posedge pclk);
  endtask
  task tend(string s);
    $display("test %s done", s);
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // whole run needs well under two thousand cycles
  initial begin
    #80000;
    err_count++;
    report_and_stop;
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 9; i++) rd("reset value", ra[i], rx[i], 0);
    tend("reset values");
    @(posedge pclk); preop_state <= 0;
    wr(8'h0c, 16'h000f, 1);
    @(posedge pclk); preop_state <= 1;
    rd("polarity kept", 8'h0c, 16'h0000, 0);
    apb(0, 8'h20, 32'h0000_0000);
    chk_bit("refusal flag", 1, rv[1]);
    wr(8'h14, 16'h1234, 1);
    wr(8'h18, 16'h0001, 1);
    rd("factor kept", 8'h14, VSF_EXP[15:0], 0);
    rd("unmapped", 8'h30, 16'h0000, 1);
    tend("refusals");
    for (int i = 0; i < 3; i++) begin
      wr(ma[i], 16'hffff, 0);
      rd("field mask", ma[i], mx[i], 0);
    end
    wr(8'h04, 16'h1d4d, 1);
    wr(8'h04, 16'h1d4c, 0);
    rd("min volt", 8'h04, 16'h1d4c, 0);
    wr(8'h08, 16'h01df, 1);
    wr(8'h08, 16'h01e0, 0);
    rd("rated", 8'h08, 16'h01e0, 0);
    wr(8'h08, 16'h021c, 0);
    tend("fields and ranges");
    wr(8'h0c, 16'h0005, 0);
    @(posedge pclk);
    vel_cmd_in <= 16'h0003; vel_add_in <= 16'h0003; vel_fb1_in <= 16'h8000; vel_fb2_in <= 16'h0003;
    step(2);
    chk_word("cmd out", 32'h0000_fffd, {16'h0000, vel_cmd_out});
    chk_word("add out", 32'h0000_0003, {16'h0000, vel_add_out});
    chk_word("fb1 out", 32'h0000_7fff, {16'h0000, vel_fb1_out});
    chk_word("fb2 out", 32'h0000_0003, {16'h0000, vel_fb2_out});
    @(posedge pclk);
    ce <= 0;
    vel_cmd_in <= 16'h0007;
    step(2);
    chk_word("cmd frozen", 32'h0000_fffd, {16'h0000, vel_cmd_out});
    ce <= 1;
    step(2);
    chk_word("cmd resumed", 32'h0000_fff9, {16'h0000, vel_cmd_out});
    tend("polarity");
    @(posedge pclk); drive_ok <= 1; ext_ok <= 1;
    wr(8'h00, 16'h0006, 0);
    step(3);
    chk_bit("ready", 0, ready_to_operate);
    @(posedge pclk); enable_in <= 1;
    step(3);
    chk_bit("ready", 1, ready_to_operate);
    chk_bit("relay", 1, emergency_relay);
    @(posedge pclk); ext_ok <= 0;
    step(3);
    chk_bit("ready", 0, ready_to_operate);
    chk_bit("relay", 0, emergency_relay);
    wr(8'h00, 16'h0016, 0);
    step(3);
    chk_bit("relay", 1, emergency_relay);
    tend("readiness");
    wr(8'h00, 16'h0001, 0);
    @(posedge pclk); controlled_mode <= 1; bus_voltage <= 16'h0170;
    wr(8'h04, 16'h0000, 0);
    step(5);
    chk_bit("uv fault", 0, undervoltage_fault);
    apb(0, 8'h20, 32'h0000_0000);
    wr(8'h04, 16'h0180, 0);
    step(5);
    chk_bit("uv fault", 1, undervoltage_fault);
    chk_bit("irq masked", 0, irq);
    wr(8'h24, 16'h0001, 0);
    step(3);
    chk_bit("irq", 1, irq);
    apb(0, 8'h20, 32'h0000_0000);
    chk_bit("uv flag", 1, rv[0]);
    step(3);
    chk_bit("irq cleared", 0, irq);
    @(posedge pclk); controlled_mode <= 0;
    step(5);
    chk_bit("uv fault", 0, undervoltage_fault);
    @(posedge pclk); controlled_mode <= 1;
    wr(8'h00, 16'h0000, 0);
    step(5);
    chk_bit("uv fault", 0, undervoltage_fault);
    tend("undervoltage");
    report_and_stop;
  end
endmodule // drp_params_tb_top

bind drp_params drp_params_sva #(.ADDR_W(ADDR_W)) u_sva (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .preop_state(preop_state), .controlled_mode(controlled_mode), .drive_ok(drive_ok),
  .vel_cmd_in(vel_cmd_in), .vel_fb1_in(vel_fb1_in), .vel_cmd_out(vel_cmd_out),
  .vel_fb1_out(vel_fb1_out), .ready_to_operate(ready_to_operate),
  .undervoltage_fault(undervoltage_fault)
);
